// ---- bench/cpc_host_model.sv ----
/* cpc_host_model: APB master standing for the controller CPU.
 * assumes: testbench offers mismatches and summarize. */
`timescale 1ns/1ps
`default_nettype none
module cpc_host_model (
	input  wire logic        pclk, pready, pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel, penable, pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// commands are levels, set by one write and dropped by a later one
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int i;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// released bus shows no stale value
		paddr   <= ~a;
		pwdata  <= ~d;
		if (pready !== 1'b1) begin
			$display("ERROR pready expected 1 seen %b", pready);
			testbench.mismatches++;
			testbench.summarize();
		end
	endtask : xfer
endmodule : cpc_host_model
`default_nettype wire

// ---- bench/cpc_monitor.sv ----
/* cpc_monitor: port assertions on cpc_core.
 * assumes: bound into cpc_core, one pclk domain. */
`timescale 1ns/1ps
`default_nettype none
module cpc_monitor import cpc_pkg::*; (
	input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire cpc_in_t     pins_in,
	input wire cpc_out_t    pins_out
);
	logic clr_seen;
	// last written clear level; the flag may only drop under it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) clr_seen <= 1'b0;
		else if (psel && penable && pwrite && pready && paddr == CPC_OFF_CMD)
			clr_seen <= pwdata[CPC_CMD_MATCH_CLR];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	one_wait_a: assert property ($rose(penable) |-> !pready ##1 pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	err_decode_a: assert property (pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0))
		else $error("pslverr wrong");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not 0");
	output_gate_a: assert property (pins_out.match_out |-> pins_out.match_flag_input)
		else $error("match out without flag");
	done_pulse_a: assert property (pins_out.preset_done |=> !pins_out.preset_done)
		else $error("preset done held");
	flag_hold_a: assert property ($fell(pins_out.match_flag_input) |-> clr_seen)
		else $error("flag dropped early");
	cov_err_c: cover property (pslverr);
	cov_match_c: cover property ($rose(pins_out.match_flag_input));
	cov_done_c: cover property (pins_out.preset_done);
endmodule : cpc_monitor
`default_nettype wire

// ---- bench/testbench.sv ----
/* testbench: cpc_core against an integer counter model.
 * assumes: cpc_pkg, cpc_core, cpc_host_model, cpc_monitor compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cpc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, pv;
	cpc_in_t     pins_in;
	cpc_out_t    pins_out;
	int          mismatches, n_tests, seed, exp_cnt;
	cpc_core u_cpc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out), .irq(irq));
	cpc_host_model u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			$display("ERROR %s expected %h seen %h", nm, ex, got);
			mismatches++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
		u_host.xfer(1'b0, a, 32'h0, q, e);
		chk(nm, ex, q);
	endtask : rd
	// registered pins need two edges before they are looked at
	task automatic settle();
		repeat (2) @(posedge pclk);
		#1;
	endtask : settle
	task automatic pulse(input int n, input logic up);
		repeat (n) begin
			@(posedge pclk);
			pins_in.up_pulse   <= up;
			pins_in.down_pulse <= !up;
		end
		@(posedge pclk);
		pins_in.up_pulse   <= 1'b0;
		pins_in.down_pulse <= 1'b0;
		exp_cnt += up ? n : -n;
	endtask : pulse
	task automatic ext(input logic v);
		@(posedge pclk);
		pins_in.ext_preset <= v;
		repeat (3) @(posedge pclk);
	endtask : ext
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		pins_in = '0;
		seed = 27;
		mismatches = 0;
		n_tests = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		pins_in.count_en <= 1'b1;
		rd(CPC_OFF_CTRL, CPC_WORD_RST, "ctrl");
		rd(CPC_OFF_COUNT, CPC_WORD_RST, "count");
		rd(8'h20, 32'h0, "unmapped");
		chk("slverr", 32'h1, {31'h0, e});
		pv = ($random(seed) & 32'hFFFF) | 32'h100;
		wr(CPC_OFF_PRESET, pv);
		wr(CPC_OFF_CTRL, 32'h3);
		wr(CPC_OFF_CMD, 32'h1);
		exp_cnt = pv;
		pulse(3, 1'b1);
		ext(1'b1);
		rd(CPC_OFF_COUNT, exp_cnt, "program preset held");
		ext(1'b0);
		wr(CPC_OFF_CMD, 32'h0);
		pulse(2, 1'b0);
		ext(1'b1);
		exp_cnt = pv;
		rd(CPC_OFF_COUNT, exp_cnt, "ext preset");
		ext(1'b0);
		rd(CPC_OFF_STATUS, 32'h1, "status no latch");
		wr(CPC_OFF_SETVAL, pv + 32'h2);
		wr(CPC_OFF_CMD, 32'h2);
		wr(CPC_OFF_CMD, 32'h0);
		wr(CPC_OFF_IRQ_ST, 32'h3);
		wr(CPC_OFF_IRQ_MK, 32'h1);
		settle();
		chk("irq idle", 32'h0, {31'h0, irq});
		chk("flag cleared", 32'h0, {31'h0, pins_out.match_flag_input});
		pulse(5, 1'b1);
		rd(CPC_OFF_COUNT, exp_cnt, "past set value");
		chk("flag held", 32'h1, {31'h0, pins_out.match_flag_input});
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(CPC_OFF_IRQ_MK, 32'h0);
		settle();
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(CPC_OFF_CTRL, 32'h1);
		wr(CPC_OFF_CMD, 32'h2);
		wr(CPC_OFF_CMD, 32'h0);
		settle();
		chk("flag reset", 32'h0, {31'h0, pins_out.match_flag_input});
		wr(CPC_OFF_SETVAL, exp_cnt);
		settle();
		chk("flag on write", 32'h1, {31'h0, pins_out.match_flag_input});
		chk("output off", 32'h0, {31'h0, pins_out.match_out});
		wr(CPC_OFF_SETVAL, pv + 32'h3);
		wr(CPC_OFF_CMD, 32'h2);
		wr(CPC_OFF_CMD, 32'h0);
		wr(CPC_OFF_IRQ_ST, 32'h1);
		wr(CPC_OFF_CTRL, 32'h7);
		ext(1'b1);
		exp_cnt = pv;
		rd(CPC_OFF_COUNT, exp_cnt, "ring ext preset");
		ext(1'b0);
		pulse(1, 1'b1);
		ext(1'b1);
		rd(CPC_OFF_COUNT, exp_cnt, "latched no preset");
		wr(CPC_OFF_CMD, 32'h4);
		u_host.xfer(1'b0, CPC_OFF_STATUS, 32'h0, q, e);
		chk("latch cleared", 32'h0, {31'h0, q[CPC_ST_EXT_LATCH]});
		ext(1'b0);
		wr(CPC_OFF_CMD, 32'h0);
		pulse(2, 1'b1);
		exp_cnt = pv;
		rd(CPC_OFF_COUNT, exp_cnt, "ring match preset");
		summarize();
	end
endmodule : testbench
bind cpc_core cpc_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .irq(irq),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pins_in(pins_in), .pins_out(pins_out));
`default_nettype wire

// ---- design/cpc_core.sv ----
/*
 * cpc_core: pulse counter with preset combining, ring-mode latches, coincidence
 * flag, APB register slave and level interrupt.
 * assumes: count pulses and the external preset pin are synchronous to pclk;
 * software holds each command bit for at least one cycle.
 */
//
// Contract
// - preset loads on rising edge of OR of program, external, ring coincidence
// - no new preset while any one preset request stays asserted
// - ring mode latches coincidence and external preset; each cleared separately
// - external latch clear works even while the external input is still high
// - set value write may raise coincidence; host disables, writes, clears, enables
// - without coincidence clear the counter keeps counting past the set value
`timescale 1ns/1ps
`default_nettype none

module cpc_core #(
	parameter int CNT_W = 32
) (
	// clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// counter pins
	input  wire cpc_pkg::cpc_in_t  pins_in,
	output cpc_pkg::cpc_out_t      pins_out,
	// interrupt
	output logic                 irq
);
	import cpc_pkg::*;

	// refused at elaboration: the count must fit one data word
	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
		$error("cpc_core: CNT_W must be 2..32");
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [3:0]          ctrl;
	logic [2:0]          cmd;
	logic [CNT_W-1:0]    set_value;
	logic [CNT_W-1:0]    preset_value;
	logic [CNT_W-1:0]    count;
	logic                match_flag_input;
	logic                ext_latch;
	logic                ring_latch;
	logic                preset_or_q;
	logic [CPC_IRQ_W-1:0] irq_status;
	logic [CPC_IRQ_W-1:0] irq_mask;

	logic wr_access;
	logic rd_access;
	logic setval_wr;
	logic ctrl_wr;
	logic cmd_wr;
	logic preset_wr;
	logic irq_st_wr;
	logic irq_mk_wr;
	logic bad_addr;
	logic equal_now;
	logic ext_req;
	logic ring_req;
	logic preset_or;
	logic preset_rise;
	logic [CPC_IRQ_W-1:0] irq_event;
	logic [CNT_W-1:0] next_count;
	logic [31:0] next_prdata;

	// writes land only at the edge where pready is sampled high, so a
	// write-one-to-clear cannot swallow an event between the two access edges
	assign wr_access = psel && penable && pwrite && pready;
	assign rd_access = psel && penable && !pwrite;
	assign bad_addr  = (paddr[1:0] != 2'h0) || (paddr > CPC_OFF_IRQ_MK);

	// ----------------------------------------------------------------
	// preset combining
	// ----------------------------------------------------------------
	// ring mode routes both sources through their latches so a short pin pulse
	// still presets once and cannot repeat until cleared
	assign equal_now = (count == set_value);
	assign ext_req   = ctrl[CPC_CTRL_RING] ? ext_latch : pins_in.ext_preset;
	assign ring_req  = ctrl[CPC_CTRL_RING] && ring_latch;
	assign preset_or = cmd[CPC_CMD_PRESET] || ext_req || ring_req;
	assign preset_rise = preset_or && !preset_or_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			preset_or_q <= 1'b0;
		else
			preset_or_q <= preset_or;
	end

	// external preset latch: clear dominates a still-high pin; armed only in
	// ring mode, so a pin pulse outside ring mode cannot preset when ring mode is switched on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ext_latch <= 1'b0;
		else if (cmd[CPC_CMD_LATCH_CLR])
			ext_latch <= 1'b0;
		else if (ctrl[CPC_CTRL_RING] && pins_in.ext_preset)
			ext_latch <= 1'b1;
	end

	// ring coincidence latch, cleared by the coincidence clear command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ring_latch <= 1'b0;
		else if (ctrl[CPC_CTRL_RING] && equal_now)
			ring_latch <= 1'b1;
		else if (cmd[CPC_CMD_MATCH_CLR])
			ring_latch <= 1'b0;
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	always_comb begin
		next_count = count;
		if (preset_rise)
			next_count = preset_value;
		else if (pins_in.count_en && ctrl[CPC_CTRL_COUNT_EN]) begin
			// no stop at the set value: counting runs on regardless of the flag
			if (pins_in.up_pulse && !pins_in.down_pulse)
				next_count = count + CNT_W'(1);
			else if (pins_in.down_pulse && !pins_in.up_pulse)
				next_count = count - CNT_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			count <= '0;
		else
			count <= next_count;
	end

	// ----------------------------------------------------------------
	// coincidence flag
	// ----------------------------------------------------------------
	// set wins over clear; a held clear only drops it once equality has gone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			match_flag_input <= 1'b0;
		else if (equal_now)
			match_flag_input <= 1'b1;
		else if (cmd[CPC_CMD_MATCH_CLR])
			match_flag_input <= 1'b0;
	end

	// ----------------------------------------------------------------
	// pin outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pins_out <= '0;
		else begin
			pins_out.match_flag_input <= match_flag_input;
			// gated so a set value write does not glitch the pin
			pins_out.match_out   <= match_flag_input && ctrl[CPC_CTRL_MATCH_EN];
			pins_out.preset_done <= preset_rise;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	assign irq_event[CPC_IRQ_MATCH]  = equal_now && !match_flag_input;
	assign irq_event[CPC_IRQ_PRESET] = preset_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_status <= '0;
		else if (irq_st_wr)
			irq_status <= (irq_status & ~pwdata[CPC_IRQ_W-1:0]) | irq_event;
		else
			irq_status <= irq_status | irq_event;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_wr   = 1'b0;
		cmd_wr    = 1'b0;
		setval_wr = 1'b0;
		preset_wr = 1'b0;
		irq_st_wr = 1'b0;
		irq_mk_wr = 1'b0;
		if (wr_access) begin
			if (paddr == CPC_OFF_CTRL)
				ctrl_wr = 1'b1;
			else if (paddr == CPC_OFF_CMD)
				cmd_wr = 1'b1;
			else if (paddr == CPC_OFF_SETVAL)
				setval_wr = 1'b1;
			else if (paddr == CPC_OFF_PRESET)
				preset_wr = 1'b1;
			else if (paddr == CPC_OFF_IRQ_ST)
				irq_st_wr = 1'b1;
			else if (paddr == CPC_OFF_IRQ_MK)
				irq_mk_wr = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl <= CPC_CTRL_RST;
		else if (ctrl_wr)
			ctrl <= pwdata[3:0];
	end

	// commands are levels: software asserts, later deasserts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd <= CPC_CMD_RST;
		else if (cmd_wr)
			cmd <= pwdata[2:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			set_value <= CNT_W'(CPC_WORD_RST);
		else if (setval_wr)
			set_value <= pwdata[CNT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			preset_value <= CNT_W'(CPC_WORD_RST);
		else if (preset_wr)
			preset_value <= pwdata[CNT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_mask <= '0;
		else if (irq_mk_wr)
			irq_mask <= pwdata[CPC_IRQ_W-1:0];
	end

	// ----------------------------------------------------------------
	// read mux and response
	// ----------------------------------------------------------------
	always_comb begin
		next_prdata = '0;
		if (paddr == CPC_OFF_CTRL)
			next_prdata[3:0] = ctrl;
		else if (paddr == CPC_OFF_CMD)
			next_prdata[2:0] = cmd;
		else if (paddr == CPC_OFF_SETVAL)
			next_prdata[CNT_W-1:0] = set_value;
		else if (paddr == CPC_OFF_PRESET)
			next_prdata[CNT_W-1:0] = preset_value;
		else if (paddr == CPC_OFF_COUNT)
			next_prdata[CNT_W-1:0] = count;
		else if (paddr == CPC_OFF_STATUS) begin
			next_prdata[CPC_ST_MATCH]      = match_flag_input;
			next_prdata[CPC_ST_EXT_LATCH]  = ext_latch;
			next_prdata[CPC_ST_RING_LATCH] = ring_latch;
			next_prdata[CPC_ST_PRESET_OR]  = preset_or_q;
		end else if (paddr == CPC_OFF_IRQ_ST)
			next_prdata[CPC_IRQ_W-1:0] = irq_status;
		else if (paddr == CPC_OFF_IRQ_MK)
			next_prdata[CPC_IRQ_W-1:0] = irq_mask;
	end

	// registered answer: one wait state, so pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && penable && !pready;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= psel && penable && !pready && bad_addr;
	end

	// data stands only with pready; zero otherwise keeps the bus quiet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else
			prdata <= (rd_access && !pready) ? next_prdata : '0;
	end

endmodule : cpc_core

`default_nettype wire

// ---- design/cpc_pkg.sv ----
/*
 * cpc_pkg: constants, register map and carrier types of the counter preset and
 * coincidence block.
 * assumes: APB with 32-bit data, one aligned word per register.
 */
package cpc_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CPC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] CPC_OFF_CMD    = 8'h04;
	localparam logic [7:0] CPC_OFF_SETVAL = 8'h08;
	localparam logic [7:0] CPC_OFF_PRESET = 8'h0C;
	localparam logic [7:0] CPC_OFF_COUNT  = 8'h10;
	localparam logic [7:0] CPC_OFF_STATUS = 8'h14;
	localparam logic [7:0] CPC_OFF_IRQ_ST = 8'h18;
	localparam logic [7:0] CPC_OFF_IRQ_MK = 8'h1C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	// ctrl
	localparam int CPC_CTRL_COUNT_EN = 0;
	localparam int CPC_CTRL_MATCH_EN = 1;
	localparam int CPC_CTRL_RING     = 2;
	localparam int CPC_CTRL_DOWN     = 3;
	// cmd (levels held by software: assert, later deassert)
	localparam int CPC_CMD_PRESET    = 0;
	localparam int CPC_CMD_MATCH_CLR = 1;
	localparam int CPC_CMD_LATCH_CLR = 2;
	// status
	localparam int CPC_ST_MATCH      = 0;
	localparam int CPC_ST_EXT_LATCH  = 1;
	localparam int CPC_ST_RING_LATCH = 2;
	localparam int CPC_ST_PRESET_OR  = 3;
	// interrupt events
	localparam int CPC_IRQ_MATCH     = 0;
	localparam int CPC_IRQ_PRESET    = 1;
	localparam int CPC_IRQ_W         = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]  CPC_CTRL_RST  = 4'h0;
	localparam logic [2:0]  CPC_CMD_RST   = 3'h0;
	localparam logic [31:0] CPC_WORD_RST  = 32'h0000_0000;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic count_en;
		logic up_pulse;
		logic down_pulse;
		logic ext_preset;
	} cpc_in_t;

	typedef struct packed {
		logic match_flag_input;
		logic match_out;
		logic preset_done;
	} cpc_out_t;

endpackage : cpc_pkg
